// [design/irq_prio_pkg.sv]
// Constants shared by the interrupt source prioritizer
package irq_prio_pkg;
  // ---------------------------------------------------------------
  // Source counts and vector width
  // ---------------------------------------------------------------
  localparam int NUM_EXT = 6;   // External request lines
  localparam int NUM_INT = 30;  // Internal peripheral requests
  localparam int NUM_VEC = 61;  // Vector numbers 0 to 60
  localparam int VEC_W   = 6;   // Width of a vector number
  localparam int ADDR_W  = 16;  // Low bits of a vector address
  localparam int ADDR_SH = 2;   // Four bytes per vector
  // ---------------------------------------------------------------
  // Vector numbers
  // ---------------------------------------------------------------
  localparam int VEC_NMI     = 7;
  localparam int VEC_EXT0    = 12;
  localparam int VEC_WDT     = 20;
  localparam int VEC_TIMER0  = 24;
  localparam int TIMER_STEP  = 4;
  localparam int TIMER_REQS  = 3;
  localparam int VEC_DMA0    = 44;
  localparam int VEC_SERIAL0 = 52;
  localparam int VEC_ADC     = 60;
  // ---------------------------------------------------------------
  // Internal request index layout
  // ---------------------------------------------------------------
  localparam int IDX_TIMER0  = 2;
  localparam int IDX_DMA0    = 17;
  localparam int IDX_SERIAL0 = 21;
  localparam int IDX_ADC     = 29;
  // Sources that may be steered to the DMA unit (timers, serial)
  localparam logic [29:0] DMA_ROUTABLE = 30'h1fe1fffc;
  // ---------------------------------------------------------------
  // Priority bit positions
  // ---------------------------------------------------------------
  localparam int PA_EXT0   = 7;
  localparam int PA_EXT1   = 6;
  localparam int PA_EXT23  = 5;
  localparam int PA_EXT45  = 4;
  localparam int PA_WDT    = 3;
  localparam int PA_TIMER0 = 2;
  localparam int PA_TIMER1 = 1;
  localparam int PA_TIMER2 = 0;
  localparam int PB_TIMER3 = 7;
  localparam int PB_TIMER4 = 6;
  localparam int PB_DMA    = 5;
  localparam int PB_SER0   = 3;
  localparam int PB_SER1   = 2;
  localparam int PB_ADC    = 1;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [5:0] FLAG_RST = 6'h00;
endpackage

// [design/interrupt_source_prioritizer.sv]
// Interrupt source prioritizer: flags, masking and vector arbitration
// Functional notes
// - NMI and lines 0-2 wake standby
// - NMI outranks all, ignores mask bits
// - Config bit picks NMI rising/falling edge
// - NMI uses vector 7
// - Per-line sense: low level or falling edge
// - Per-line enable blocks external requests
// - Four group bits set external priorities
// - Line flags readable, cleared by writing zero
// - External lines use vectors 12 to 17
// - Detection independent of pin direction
// - Thirty enabled internal peripheral requests accepted
// - DMA-routed timer/serial requests never interrupt
// - Smaller vector wins by default
// - Priority bits reorder; reset gives default
// - Vector address is four times number
// - Timer channels: three vectors from 24
// - Serial channels use vectors 52 to 59
// - Watchdog 20, refresh 21, DMA, converter
// - Priority bit set means high; resets 0
// - Flag sets on low level or fall
// - Equal levels resolved by vector order
`timescale 1ns/1ps
module interrupt_source_prioritizer
  import irq_prio_pkg::*;
(
  input  wire logic                MCLK,
  input  wire logic                SRST,
  input  wire logic                NMI_PIN,
  input  wire logic                NMI_EDGE_SELECT,
  input  wire logic [NUM_EXT-1:0]  EXT_REQ_N,
  input  wire logic [NUM_EXT-1:0]  EXT_SENSE_SELECT,
  input  wire logic [NUM_EXT-1:0]  EXT_REQUEST_ENABLES,
  input  wire logic [NUM_EXT-1:0]  EXT_FLAG_CLEAR,
  input  wire logic [7:0]          PRIORITY_GROUP_A,
  input  wire logic [7:0]          PRIORITY_GROUP_B,
  input  wire logic                PRIORITY_LOAD,
  input  wire logic [NUM_INT-1:0]  INT_REQ,
  input  wire logic [NUM_INT-1:0]  INT_DMA_ROUTE,
  input  wire logic                USER_MASK_ENABLE,
  input  wire logic                CPU_MASK_BIT,
  input  wire logic                USER_MASK_BIT,
  input  wire logic                IRQ_ACK,
  output logic [NUM_EXT-1:0]       EXT_REQUEST_FLAGS,
  output logic                     IRQ_VALID,
  output logic [VEC_W-1:0]         IRQ_VECTOR,
  output logic [ADDR_W-1:0]        IRQ_VECTOR_ADDR,
  output logic                     WAKE
);

  // ---------------------------------------------------------------
  // Source map helpers
  // ---------------------------------------------------------------
  // Vector number of internal request index i
  function automatic int int_vec(input int i);
    int r;
    r = 0;
    if (i < IDX_TIMER0) begin
      r = VEC_WDT + i;
    end else if (i < IDX_DMA0) begin
      r = VEC_TIMER0 + TIMER_STEP * ((i - IDX_TIMER0) / TIMER_REQS)
          + ((i - IDX_TIMER0) % TIMER_REQS);
    end else if (i < IDX_SERIAL0) begin
      r = VEC_DMA0 + (i - IDX_DMA0);
    end else if (i < IDX_ADC) begin
      r = VEC_SERIAL0 + (i - IDX_SERIAL0);
    end else begin
      r = VEC_ADC;
    end
    return r;
  endfunction

  // Priority level of vector v under the given group bits
  function automatic logic prio_of(input int v, input logic [7:0] a,
                                   input logic [7:0] b);
    logic p;
    p = 1'b0;
    if (v == VEC_EXT0) p = a[PA_EXT0];
    else if (v == VEC_EXT0 + 1) p = a[PA_EXT1];
    else if (v < VEC_EXT0 + 4) p = a[PA_EXT23];
    else if (v < VEC_EXT0 + 6) p = a[PA_EXT45];
    else if (v < VEC_TIMER0) p = a[PA_WDT];
    else if (v < VEC_TIMER0 + 4) p = a[PA_TIMER0];
    else if (v < VEC_TIMER0 + 8) p = a[PA_TIMER1];
    else if (v < VEC_TIMER0 + 12) p = a[PA_TIMER2];
    else if (v < VEC_TIMER0 + 16) p = b[PB_TIMER3];
    else if (v < VEC_DMA0) p = b[PB_TIMER4];
    else if (v < VEC_SERIAL0) p = b[PB_DMA];
    else if (v < VEC_SERIAL0 + 4) p = b[PB_SER0];
    else if (v < VEC_ADC) p = b[PB_SER1];
    else p = b[PB_ADC];
    return p;
  endfunction

  // True for vectors that belong to a real source
  function automatic logic is_source(input int v);
    logic s;
    s = (v == VEC_NMI);
    for (int k = 0; k < NUM_EXT; k++) s |= (v == VEC_EXT0 + k);
    for (int k = 0; k < NUM_INT; k++) s |= (v == int_vec(k));
    return s;
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]         prio_a;    // Held priority group A
  logic [7:0]         prio_b;    // Held priority group B
  logic               nmi_prev;  // Last NMI pin sample
  logic [NUM_EXT-1:0] ext_prev;  // Last external pin samples
  logic               primed;    // Previous samples are valid
  logic               nmi_flag;  // NMI pending
  logic               nmi_event; // Selected NMI edge seen now
  logic [NUM_EXT-1:0] ext_set;   // Flag set conditions this cycle
  logic [NUM_EXT-1:0] ext_ack;   // Edge flags consumed by handling
  logic [NUM_VEC-1:0] pend;      // Enabled requests by vector
  logic [NUM_VEC-1:0] elig;      // Requests passing the CPU masks
  logic               mask_lo;   // Level 0 sources masked
  logic               mask_hi;   // Level 1 sources masked
  logic               next_valid;
  logic [VEC_W-1:0]   next_vector;
  logic               nmi_event_d; // Delayed NMI event, wake check only

  // ---------------------------------------------------------------
  // Priority bits
  // ---------------------------------------------------------------
  // Loaded by software; cleared to the default order on reset
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      prio_a <= PRIO_RST;
      prio_b <= PRIO_RST;
    end else if (PRIORITY_LOAD) begin
      prio_a <= PRIORITY_GROUP_A;
      prio_b <= PRIORITY_GROUP_B;
    end
  end

  // ---------------------------------------------------------------
  // Pin edge detection
  // ---------------------------------------------------------------
  // Pins are read directly, so direction setting has no effect
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      nmi_prev <= 1'b0;
      ext_prev <= '1;
      primed   <= 1'b0;
    end else begin
      nmi_prev <= NMI_PIN;
      ext_prev <= EXT_REQ_N;
      primed   <= 1'b1;
    end
  end

  // Selected NMI edge; no edge counts before samples are primed
  assign nmi_event = primed && (NMI_EDGE_SELECT ?
                     (NMI_PIN && !nmi_prev) :
                     (!NMI_PIN && nmi_prev));

  // Low level or falling edge, per line sense bit
  always_comb begin
    for (int k = 0; k < NUM_EXT; k++) begin
      ext_set[k] = EXT_SENSE_SELECT[k] ?
                   (primed && ext_prev[k] && !EXT_REQ_N[k]) :
                   !EXT_REQ_N[k];
      ext_ack[k] = IRQ_ACK && IRQ_VALID && EXT_SENSE_SELECT[k] &&
                   (IRQ_VECTOR == VEC_W'(VEC_EXT0 + k));
    end
  end

  // ---------------------------------------------------------------
  // Request flags
  // ---------------------------------------------------------------
  // NMI pending, cleared when its vector is taken; set wins
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      nmi_flag <= 1'b0;
    end else if (nmi_event) begin
      nmi_flag <= 1'b1;
    end else if (IRQ_ACK && IRQ_VALID &&
                 IRQ_VECTOR == VEC_W'(VEC_NMI)) begin
      nmi_flag <= 1'b0;
    end
  end

  // External flags: set wins over software or handling clear
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      EXT_REQUEST_FLAGS <= FLAG_RST;
    end else begin
      EXT_REQUEST_FLAGS <= ext_set |
        (EXT_REQUEST_FLAGS & ~EXT_FLAG_CLEAR & ~ext_ack);
    end
  end

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  // Three-level masking from the mask mode and CPU mask bits
  assign mask_lo = CPU_MASK_BIT;
  assign mask_hi = CPU_MASK_BIT && (USER_MASK_ENABLE || USER_MASK_BIT);

  // Gather enabled requests at their vector positions
  always_comb begin
    pend = '0;
    for (int k = 0; k < NUM_EXT; k++) begin
      pend[VEC_EXT0 + k] = EXT_REQUEST_FLAGS[k] &&
                           EXT_REQUEST_ENABLES[k];
    end
    for (int i = 0; i < NUM_INT; i++) begin
      pend[int_vec(i)] = INT_REQ[i] &&
        !(INT_DMA_ROUTE[i] && DMA_ROUTABLE[i]);
    end
    for (int v = 0; v < NUM_VEC; v++) begin
      elig[v] = pend[v] &&
        !(prio_of(v, prio_a, prio_b) ? mask_hi : mask_lo);
    end
  end

  // Level 1 beats level 0; lower vector wins inside a level
  always_comb begin
    next_valid  = 1'b0;
    next_vector = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (elig[v] && !prio_of(v, prio_a, prio_b)) begin
        next_valid  = 1'b1;
        next_vector = VEC_W'(v);
      end
    end
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (elig[v] && prio_of(v, prio_a, prio_b)) begin
        next_valid  = 1'b1;
        next_vector = VEC_W'(v);
      end
    end
    if (nmi_flag) begin
      next_valid  = 1'b1;
      next_vector = VEC_W'(VEC_NMI);
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the CPU core
  // ---------------------------------------------------------------
  // Winner registered every cycle with its vector address
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      IRQ_VALID       <= 1'b0;
      IRQ_VECTOR      <= '0;
      IRQ_VECTOR_ADDR <= '0;
    end else begin
      IRQ_VALID       <= next_valid;
      IRQ_VECTOR      <= next_vector;
      IRQ_VECTOR_ADDR <= ADDR_W'({next_vector, 2'b00});
    end
  end

  // Standby wake from NMI and external lines 0 to 2 only
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= nmi_event || nmi_flag ||
              |(ext_set[2:0] & EXT_REQUEST_ENABLES[2:0]);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // One-cycle delayed NMI event, read only by the wake check
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      nmi_event_d <= 1'b0;
    end else begin
      nmi_event_d <= nmi_event;
    end
  end

  AST_NMI_WINS: assert property (@(posedge MCLK) disable iff (SRST)
    nmi_flag |=> IRQ_VALID && IRQ_VECTOR == VEC_W'(VEC_NMI))
    else $error("pending NMI did not present vector 7");
  AST_NMI_EDGE: assert property (@(posedge MCLK) disable iff (SRST)
    (primed && NMI_EDGE_SELECT && $rose(NMI_PIN)) |=> ##1
    (IRQ_VALID && IRQ_VECTOR == VEC_W'(VEC_NMI)))
    else $error("rising NMI edge not presented");
  AST_LEVEL_SET: assert property (@(posedge MCLK) disable iff (SRST)
    (!EXT_SENSE_SELECT[0] && !EXT_REQ_N[0]) |=> EXT_REQUEST_FLAGS[0])
    else $error("low level did not set line flag");
  AST_EDGE_ONLY: assert property (@(posedge MCLK) disable iff (SRST)
    (EXT_SENSE_SELECT[1] && !EXT_REQUEST_FLAGS[1] && !EXT_REQ_N[1] &&
     !$past(EXT_REQ_N[1])) |=> !EXT_REQUEST_FLAGS[1])
    else $error("edge mode flag set without a fall");
  AST_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
    (EXT_FLAG_CLEAR[2] && EXT_REQ_N[2]) |=> !EXT_REQUEST_FLAGS[2])
    else $error("write of zero did not clear flag");
  AST_BLOCKED: assert property (@(posedge MCLK) disable iff (SRST)
    !$past(EXT_REQUEST_ENABLES[0]) |->
    !(IRQ_VALID && IRQ_VECTOR == VEC_W'(VEC_EXT0)))
    else $error("disabled line won arbitration");
  AST_DMA_ROUTE: assert property (@(posedge MCLK) disable iff (SRST)
    $past(INT_DMA_ROUTE[IDX_TIMER0]) |->
    !(IRQ_VALID && IRQ_VECTOR == VEC_W'(VEC_TIMER0)))
    else $error("DMA-routed request reached the CPU");
  AST_DEFAULT_ORDER: assert property (@(posedge MCLK) disable iff (SRST)
    (INT_REQ[0] && INT_REQ[1] && !nmi_flag && !CPU_MASK_BIT &&
     prio_a == PRIO_RST && prio_b == PRIO_RST && pend[19:0] == '0)
    |=> IRQ_VECTOR == VEC_W'(VEC_WDT))
    else $error("default order not followed");
  AST_NO_RESERVED: assert property (@(posedge MCLK) disable iff (SRST)
    IRQ_VALID |-> is_source(int'(IRQ_VECTOR)))
    else $error("reserved vector presented");
  AST_ADDR: assert property (@(posedge MCLK) disable iff (SRST)
    IRQ_VECTOR_ADDR == ADDR_W'({IRQ_VECTOR, 2'b00}))
    else $error("vector address not four times vector");
  AST_WAKE: assert property (@(posedge MCLK) disable iff (SRST)
    (nmi_event || (!EXT_SENSE_SELECT[3] && !EXT_REQ_N[3] &&
     EXT_REQUEST_ENABLES[3] && !nmi_flag && !nmi_event &&
     (ext_set[2:0] & EXT_REQUEST_ENABLES[2:0]) == '0))
    |=> WAKE == nmi_event_d)
    else $error("wake source wrong");

endmodule

// [verification/cpu_model.sv]
// CPU-side model that accepts one presented vector per ack_en window
`timescale 1ns/1ps
module cpu_model
  import irq_prio_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             SRST,
  input  wire logic             ack_en,
  input  wire logic             irq_valid,
  input  wire logic [VEC_W-1:0] irq_vector,
  output logic                  irq_ack,
  output logic [VEC_W-1:0]      taken
);
  logic done;  // One acceptance already made while enabled
  // -------------------------------------------------------------
  // Acceptance
  // -------------------------------------------------------------
  // Single-cycle acknowledge; done stops a second take of a vector
  // that is still shown while the device drops its flag
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      irq_ack <= 1'b0;
      taken   <= '0;
      done    <= 1'b0;
    end else if (ack_en && irq_valid && !done) begin
      irq_ack <= 1'b1;
      taken   <= irq_vector;
      done    <= 1'b1;
    end else begin
      irq_ack <= 1'b0;
      if (!ack_en) begin
        done <= 1'b0;
      end
    end
  end
endmodule

// [verification/tb_interrupt_source_prioritizer.sv]
// Self-checking bench for the interrupt source prioritizer
`timescale 1ns/1ps
module tb_interrupt_source_prioritizer
  import irq_prio_pkg::*;
;
  // -------------------------------------------------------------
  // Stimulus and observed nets
  // -------------------------------------------------------------
  logic               MCLK = 1'b0, SRST = 1'b1, ack_en = 1'b0;
  logic               NMI_PIN = 1'b0, NMI_EDGE_SELECT = 1'b1;
  logic [NUM_EXT-1:0] EXT_REQ_N = 6'h3f;  // Pins kept as inputs
  logic [NUM_EXT-1:0] EXT_SENSE_SELECT = 6'h00, EXT_FLAG_CLEAR = 6'h00;
  logic [NUM_EXT-1:0] EXT_REQUEST_ENABLES = 6'h00, EXT_REQUEST_FLAGS;
  logic [7:0]         PRIORITY_GROUP_A = 8'h00, PRIORITY_GROUP_B = 8'h00;
  logic               PRIORITY_LOAD = 1'b0, IRQ_ACK, IRQ_VALID, WAKE;
  logic [NUM_INT-1:0] INT_REQ = '0, INT_DMA_ROUTE = '0;
  logic               USER_MASK_ENABLE = 1'b0, CPU_MASK_BIT = 1'b0;
  logic               USER_MASK_BIT = 1'b0;
  logic [VEC_W-1:0]   IRQ_VECTOR, taken;
  logic [ADDR_W-1:0]  IRQ_VECTOR_ADDR;
  int                 n_mismatch = 0, checked = 0;
  interrupt_source_prioritizer u_dut (.MCLK(MCLK), .SRST(SRST),
    .NMI_PIN(NMI_PIN), .NMI_EDGE_SELECT(NMI_EDGE_SELECT),
    .EXT_REQ_N(EXT_REQ_N), .EXT_SENSE_SELECT(EXT_SENSE_SELECT),
    .EXT_REQUEST_ENABLES(EXT_REQUEST_ENABLES),
    .EXT_FLAG_CLEAR(EXT_FLAG_CLEAR), .PRIORITY_GROUP_A(PRIORITY_GROUP_A),
    .PRIORITY_GROUP_B(PRIORITY_GROUP_B), .PRIORITY_LOAD(PRIORITY_LOAD),
    .INT_REQ(INT_REQ), .INT_DMA_ROUTE(INT_DMA_ROUTE),
    .USER_MASK_ENABLE(USER_MASK_ENABLE), .CPU_MASK_BIT(CPU_MASK_BIT),
    .USER_MASK_BIT(USER_MASK_BIT), .IRQ_ACK(IRQ_ACK),
    .EXT_REQUEST_FLAGS(EXT_REQUEST_FLAGS), .IRQ_VALID(IRQ_VALID),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_VECTOR_ADDR(IRQ_VECTOR_ADDR),
    .WAKE(WAKE));
  cpu_model u_cpu (.MCLK(MCLK), .SRST(SRST), .ack_en(ack_en),
    .irq_valid(IRQ_VALID), .irq_vector(IRQ_VECTOR), .irq_ack(IRQ_ACK),
    .taken(taken));
  // -------------------------------------------------------------
  // Shared helpers
  // -------------------------------------------------------------
  initial forever #4 MCLK = ~MCLK;
  // Wait n edges, then let their updates settle
  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Winner shown with its address
  task automatic chk_vec(input logic [5:0] v);
    check("irq_valid", 16'(IRQ_VALID), 16'h1);
    check("irq_vector", 16'(IRQ_VECTOR), 16'(v));
    check("irq_vector_addr", IRQ_VECTOR_ADDR, 16'(v) << 2);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // One internal request at a time lands on its own vector
  task automatic t_internal;
    int idx_t[9] = '{0, 1, 2, 4, 5, 16, 17, 21, 29};
    int vec_t[9] = '{20, 21, 24, 26, 28, 42, 44, 52, 60};
    for (int i = 0; i < 9; i++) begin
      @(posedge MCLK);
      INT_REQ <= 30'h1 << idx_t[i];
      step(1);
      chk_vec(6'(vec_t[i]));
    end
  endtask
  // Default order and steering to the DMA unit
  task automatic t_order;
    @(posedge MCLK);
    INT_REQ <= 30'h20000007;
    INT_DMA_ROUTE <= 30'h4;
    step(1);
    chk_vec(6'd20);
    INT_REQ <= 30'h4;
    step(1);
    check("routed_valid", 16'(IRQ_VALID), 16'h0);
    INT_DMA_ROUTE <= 30'h20000;
    INT_REQ <= 30'h20000;
    step(1);
    chk_vec(6'd44);
    INT_REQ <= '0;
    INT_DMA_ROUTE <= '0;
  endtask
  // Edge lines: flag, vector, wake, then acknowledge or clear
  task automatic t_ext_edge;
    @(posedge MCLK);
    EXT_SENSE_SELECT <= 6'h09;
    EXT_REQUEST_ENABLES <= 6'h3f;
    step(2);
    EXT_REQ_N <= 6'h3e;
    step(1);
    check("flags_edge", 16'(EXT_REQUEST_FLAGS), 16'h1);
    check("wake_line0", 16'(WAKE), 16'h1);
    step(1);
    chk_vec(6'd12);
    EXT_REQ_N <= 6'h3f;
    ack_en <= 1'b1;
    step(4);
    check("flags_taken", 16'(EXT_REQUEST_FLAGS), 16'h0);
    check("taken_vec", 16'(taken), 16'd12);
    ack_en <= 1'b0;
    EXT_REQ_N <= 6'h37;
    step(1);
    check("wake_line3", 16'(WAKE), 16'h0);
    EXT_REQ_N <= 6'h3f;
    step(1);
    chk_vec(6'd15);
    EXT_FLAG_CLEAR <= 6'h08;
    step(1);
    EXT_FLAG_CLEAR <= 6'h00;
    step(1);
    check("flags_clr", 16'(EXT_REQUEST_FLAGS), 16'h0);
  endtask
  // Level lines, group priority, refused clear, disabled line
  task automatic t_ext_level;
    @(posedge MCLK);
    EXT_SENSE_SELECT <= 6'h00;
    PRIORITY_GROUP_A <= 8'h20;
    PRIORITY_LOAD <= 1'b1;
    EXT_REQ_N <= 6'h16;
    @(posedge MCLK);
    PRIORITY_LOAD <= 1'b0;
    EXT_FLAG_CLEAR <= 6'h3f;
    step(2);
    check("flags_level", 16'(EXT_REQUEST_FLAGS), 16'h29);
    chk_vec(6'd15);
    EXT_FLAG_CLEAR <= 6'h00;
    EXT_REQ_N <= 6'h3f;
    step(1);
    EXT_FLAG_CLEAR <= 6'h3f;
    step(1);
    EXT_FLAG_CLEAR <= 6'h00;
    EXT_REQUEST_ENABLES <= 6'h2f;
    EXT_REQ_N <= 6'h2f;
    step(3);
    check("disabled_valid", 16'(IRQ_VALID), 16'h0);
    EXT_REQ_N <= 6'h3f;
  endtask
  // Either edge choice of the pin raises vector 7 through full masking
  task automatic t_nmi;
    for (int s = 0; s < 2; s++) begin
      @(posedge MCLK);
      NMI_EDGE_SELECT <= s[0];
      NMI_PIN <= ~s[0];
      CPU_MASK_BIT <= 1'b1;
      USER_MASK_BIT <= 1'b1;
      INT_REQ <= 30'h1;
      step(3);
      NMI_PIN <= s[0];
      step(2);
      chk_vec(6'd7);
      check("wake_nmi", 16'(WAKE), 16'h1);
      ack_en <= 1'b1;
      step(4);
      check("nmi_taken", 16'(taken), 16'd7);
      check("masked_valid", 16'(IRQ_VALID), 16'h0);
      ack_en <= 1'b0;
    end
  endtask
  // Level-1 sources reorder, ties by vector, mask modes, reset
  task automatic t_prio;
    @(posedge MCLK);
    PRIORITY_GROUP_B <= 8'h0a;
    PRIORITY_LOAD <= 1'b1;
    INT_REQ <= 30'h20200001;
    USER_MASK_BIT <= 1'b0;
    @(posedge MCLK);
    PRIORITY_LOAD <= 1'b0;
    step(1);
    chk_vec(6'd52);
    USER_MASK_BIT <= 1'b1;
    step(1);
    check("all_masked", 16'(IRQ_VALID), 16'h0);
    USER_MASK_BIT <= 1'b0;
    USER_MASK_ENABLE <= 1'b1;
    step(1);
    check("cpu_bit_masks", 16'(IRQ_VALID), 16'h0);
    USER_MASK_ENABLE <= 1'b0;
    CPU_MASK_BIT <= 1'b0;
    SRST <= 1'b1;
    step(1);
    SRST <= 1'b0;
    step(3);
    chk_vec(6'd20);
  endtask
  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (4) @(posedge MCLK);
    SRST <= 1'b0;
    step(1);
    check("reset_valid", 16'(IRQ_VALID), 16'h0);
    check("reset_flags", 16'(EXT_REQUEST_FLAGS), 16'h0);
    step(1);
    t_internal();
    t_order();
    t_ext_edge();
    t_ext_level();
    t_nmi();
    t_prio();
    wrap_up();
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule
